// >>> hw/jtc_defines.vh
// Purpose: constants for the test access port instruction and data chains
// Assumes: one system clock, the test clock sampled as an ordinary input
// Notes: boundary chain width follows the pad count below
// Contract
// [RULE1] four-bit instruction chain with update holding register
// [RULE2] code 0000 drives pads from preloaded cells
// [RULE3] code 0001 drives core inputs from cells
// [RULE4] boundary chain stays accessible under both tests
// [RULE5] code 0010 samples pads, shifts preload in
// [RULE6] codes 1000/1010/1011 select the debug chains
// [RULE7] code 1110 selects and loads identification chain
// [RULE8] code 1111 gives a one-stage bypass path
// [RULE9] unlisted codes behave exactly like bypass
// [RULE10] identification code after reset or logic-reset
// [RULE11] identification capture bit zero is one
// [RULE12] bypass is one bit, captures zero
// [RULE13] three cells per pad: in, out, enable
// [RULE14] boundary captures all pads in Capture-DR
// [RULE15] boundary shifts out on TDO in Shift-DR
// [RULE16] Update-DR loads boundary holding cells
// [RULE17] reset pin cell observe-only, never driven
// [RULE18] the three debug chains are 35 bits
// [RULE19] abort chain update clears flags or abandons
// [RULE20] access-port chain performs bus access, returns data
// [RULE21] TDO changes only on falling test clock
// [RULE22] reset or TRST forces Test-Logic-Reset
// [RULE23] debug capture returns result plus 3-bit acknowledge
// [RULE24] instruction capture loads pattern ending in 01
`ifndef JTC_DEFINES_VH
`define JTC_DEFINES_VH
`define JTC_IR_W 4
`define JTC_IR_EXTEST 4'h0
`define JTC_IR_INTEST 4'h1
`define JTC_IR_SAMPLE 4'h2
`define JTC_IR_ABORT 4'h8
`define JTC_IR_DP_ACCESS 4'ha
`define JTC_IR_AP_ACCESS 4'hb
`define JTC_IR_IDCODE 4'he
`define JTC_IR_BYPASS 4'hf
`define JTC_IR_CAPTURE 4'h1
`define JTC_DBG_W 35
`define JTC_ID_W 32
// arbitrary identification value, bit 0 set
`define JTC_IDCODE_VAL 32'h0a5a_5001
`define JTC_NPADS 8
`define JTC_BSR_W 24
`define JTC_RSTPAD 0
`define JTC_ACK_OK 3'h2
`define JTC_ACK_WAIT 3'h1
`define JTC_FIFO_W 35
`define JTC_FIFO_D 32
`define JTC_FIFO_AW 5
`define JTC_FIFO_CW 6
`endif

// >>> hw/jtc_chains.v
// Purpose: instruction and data chains behind a test access port
// Assumes: tck, tms, tdi and trst arrive asynchronously and are synchronised
// Notes: debug requests leave through a 32-word fifo to the core side
`include "jtc_defines.vh"

// ==========================================================
// request fifo
module jtc_fifo #(
    parameter W = 35,
    parameter D = 32,
    parameter AW = 5,
    parameter CW = 6
) (
    input wire mclk_in,
    input wire rst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg [W-1:0] mem_q [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [CW-1:0] cnt_q;
    // count is one bit wider than the pointers so full and empty differ
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    assign in_ready_out = (cnt_q != D[CW-1:0]);
    assign out_valid_out = (cnt_q != {CW{1'b0}});
    assign out_data_out = mem_q[rd_q];
    always @(posedge mclk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {CW{1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ==========================================================
// top: tap, chains, boundary cells
module jtc_chains (
    input wire mclk_in,
    input wire rst_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire trst_n_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    input wire [`JTC_NPADS-1:0] pad_in_in,
    input wire [`JTC_NPADS-1:0] core_out_in,
    input wire [`JTC_NPADS-1:0] core_oe_in,
    output reg [`JTC_NPADS-1:0] pad_out_out,
    output reg [`JTC_NPADS-1:0] pad_oe_out,
    output reg [`JTC_NPADS-1:0] core_in_out,
    output reg req_valid_out,
    input wire req_ready_in,
    output reg [`JTC_DBG_W-1:0] req_data_out,
    input wire rsp_valid_in,
    input wire [31:0] rsp_data_in,
    input wire [2:0] rsp_ack_in,
    output reg abort_out,
    output reg [3:0] err_clear_out
);
    localparam [15:0] S_TLR = 16'h0001;
    localparam [15:0] S_RTI = 16'h0002;
    localparam [15:0] S_SDR = 16'h0004;
    localparam [15:0] S_CDR = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_E1DR = 16'h0020;
    localparam [15:0] S_PDR = 16'h0040;
    localparam [15:0] S_E2DR = 16'h0080;
    localparam [15:0] S_UDR = 16'h0100;
    localparam [15:0] S_SIR = 16'h0200;
    localparam [15:0] S_CIR = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_E1IR = 16'h1000;
    localparam [15:0] S_PIR = 16'h2000;
    localparam [15:0] S_E2IR = 16'h4000;
    localparam [15:0] S_UIR = 16'h8000;
    localparam [2:0] SEL_BYP = 3'h0;
    localparam [2:0] SEL_ID = 3'h1;
    localparam [2:0] SEL_BSR = 3'h2;
    localparam [2:0] SEL_ABT = 3'h3;
    localparam [2:0] SEL_DP = 3'h4;
    localparam [2:0] SEL_AP = 3'h5;

    // ======================================================
    // input synchronisers
    reg [1:0] tck_s_q;
    reg [1:0] tms_s_q;
    reg [1:0] tdi_s_q;
    reg [1:0] trst_s_q;
    reg tck_d1_q;
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tck_s_q <= 2'h0;
            tms_s_q <= 2'h0;
            tdi_s_q <= 2'h0;
            trst_s_q <= 2'h0;
            tck_d1_q <= 1'b0;
        end else begin
            tck_s_q <= {tck_s_q[0], tck_in};
            tms_s_q <= {tms_s_q[0], tms_in};
            tdi_s_q <= {tdi_s_q[0], tdi_in};
            trst_s_q <= {trst_s_q[0], trst_n_in};
            tck_d1_q <= tck_s_q[1];
        end
    end
    wire rise = tck_s_q[1] && !tck_d1_q;
    wire fall = !tck_s_q[1] && tck_d1_q;
    wire tms = tms_s_q[1];
    wire tdi = tdi_s_q[1];
    wire trst = !trst_s_q[1];

    // ======================================================
    // pad input synchroniser: pads toggle freely against mclk
    reg [`JTC_NPADS-1:0] pad_s1_q;
    reg [`JTC_NPADS-1:0] pad_s2_q;
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pad_s1_q <= {`JTC_NPADS{1'b0}};
            pad_s2_q <= {`JTC_NPADS{1'b0}};
        end else begin
            pad_s1_q <= pad_in_in;
            pad_s2_q <= pad_s1_q;
        end
    end

    // ======================================================
    // tap state machine
    reg [15:0] st_q;
    reg [15:0] st_d;
    always @* begin
        st_d = st_q;
        case (st_q)
            S_TLR: st_d = tms ? S_TLR : S_RTI;
            S_RTI: st_d = tms ? S_SDR : S_RTI;
            S_SDR: st_d = tms ? S_SIR : S_CDR;
            S_CDR: st_d = tms ? S_E1DR : S_SHDR;
            S_SHDR: st_d = tms ? S_E1DR : S_SHDR;
            S_E1DR: st_d = tms ? S_UDR : S_PDR;
            S_PDR: st_d = tms ? S_E2DR : S_PDR;
            S_E2DR: st_d = tms ? S_UDR : S_SHDR;
            S_UDR: st_d = tms ? S_SDR : S_RTI;
            S_SIR: st_d = tms ? S_TLR : S_CIR;
            S_CIR: st_d = tms ? S_E1IR : S_SHIR;
            S_SHIR: st_d = tms ? S_E1IR : S_SHIR;
            S_E1IR: st_d = tms ? S_UIR : S_PIR;
            S_PIR: st_d = tms ? S_E2IR : S_PIR;
            S_E2IR: st_d = tms ? S_UIR : S_SHIR;
            S_UIR: st_d = tms ? S_SDR : S_RTI;
            default: st_d = S_TLR;
        endcase
    end

    // ======================================================
    // instruction decode
    reg [`JTC_IR_W-1:0] ir_sh_q;
    reg [`JTC_IR_W-1:0] ir_q;
    reg [2:0] sel;
    always @* begin
        case (ir_q)
            `JTC_IR_EXTEST, `JTC_IR_INTEST,
            `JTC_IR_SAMPLE: sel = SEL_BSR; // [RULE4] [RULE5]
            `JTC_IR_ABORT: sel = SEL_ABT; // [RULE6]
            `JTC_IR_DP_ACCESS: sel = SEL_DP; // [RULE6]
            `JTC_IR_AP_ACCESS: sel = SEL_AP; // [RULE6]
            `JTC_IR_IDCODE: sel = SEL_ID; // [RULE7]
            default: sel = SEL_BYP; // [RULE8] [RULE9]
        endcase
    end

    // ======================================================
    // chains
    reg byp_q;
    reg [`JTC_ID_W-1:0] id_q;
    reg [`JTC_DBG_W-1:0] dbg_q;
    reg [`JTC_BSR_W-1:0] bsr_q;
    reg [`JTC_BSR_W-1:0] bsr_upd_q;
    reg [31:0] rd_data_q;
    reg [2:0] ack_q;
    reg pend_q;
    wire [`JTC_BSR_W-1:0] bsr_cap;
    genvar g;
    generate
        for (g = 0; g < `JTC_NPADS; g = g + 1) begin : cells
            // pad 0 sits next to the port pins; order in, out, enable
            assign bsr_cap[3*g] = pad_s2_q[g]; // [RULE13] [RULE14]
            assign bsr_cap[3*g+1] = pad_out_out[g];
            assign bsr_cap[3*g+2] = pad_oe_out[g];
        end
    endgenerate
    wire ser_out = (sel == SEL_BYP) ? byp_q :
        (sel == SEL_ID) ? id_q[0] :
        (sel == SEL_BSR) ? bsr_q[0] : dbg_q[0];
    wire dr_cap = rise && st_q == S_CDR;
    wire dr_sh = rise && st_q == S_SHDR;
    wire dr_upd = rise && st_q == S_E1DR && tms
        || rise && st_q == S_E2DR && tms;
    // fifo full drops a request: it is then answered with a wait ack
    wire fifo_rdy;
    wire fifo_ok = dr_upd && (sel == SEL_DP || sel == SEL_AP) && fifo_rdy;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= S_TLR; // [RULE22]
            ir_sh_q <= `JTC_IR_CAPTURE;
            ir_q <= `JTC_IR_IDCODE; // [RULE10]
            byp_q <= 1'b0;
            id_q <= {`JTC_ID_W{1'b0}};
            dbg_q <= {`JTC_DBG_W{1'b0}};
            bsr_q <= {`JTC_BSR_W{1'b0}};
            bsr_upd_q <= {`JTC_BSR_W{1'b0}};
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
            rd_data_q <= 32'h0;
            ack_q <= `JTC_ACK_OK;
            pend_q <= 1'b0;
            abort_out <= 1'b0;
            err_clear_out <= 4'h0;
        end else if (trst) begin
            // released pin idles on its pull-up while not shifting
            st_q <= S_TLR; // [RULE22]
            ir_q <= `JTC_IR_IDCODE; // [RULE10]
            tdo_oe_out <= 1'b0;
            abort_out <= 1'b0;
            err_clear_out <= 4'h0;
        end else begin
            abort_out <= 1'b0;
            err_clear_out <= 4'h0;
            if (rsp_valid_in) begin
                rd_data_q <= rsp_data_in; // [RULE20]
                ack_q <= rsp_ack_in;
                pend_q <= 1'b0;
            end
            if (rise) begin
                st_q <= st_d;
                if (st_q == S_TLR) begin
                    ir_q <= `JTC_IR_IDCODE; // [RULE10]
                end
                if (st_q == S_CIR) begin
                    ir_sh_q <= `JTC_IR_CAPTURE; // [RULE24]
                end else if (st_q == S_SHIR) begin
                    ir_sh_q <= {tdi, ir_sh_q[`JTC_IR_W-1:1]}; // [RULE1]
                end
                if ((st_q == S_E1IR || st_q == S_E2IR) && tms) begin
                    ir_q <= ir_sh_q; // [RULE1]
                end
            end
            if (dr_cap) begin
                byp_q <= 1'b0; // [RULE12]
                if (sel == SEL_ID) begin
                    id_q <= `JTC_IDCODE_VAL; // [RULE7] [RULE11]
                end
                if (sel == SEL_BSR) begin
                    bsr_q <= bsr_cap; // [RULE14]
                end
                if (sel == SEL_DP || sel == SEL_AP) begin
                    dbg_q <= {rd_data_q, pend_q ? `JTC_ACK_WAIT : ack_q};
                end // [RULE23]
                if (sel == SEL_ABT) begin
                    dbg_q <= {`JTC_DBG_W{1'b0}};
                end
            end else if (dr_sh) begin
                byp_q <= tdi; // [RULE8]
                id_q <= {tdi, id_q[`JTC_ID_W-1:1]};
                bsr_q <= {tdi, bsr_q[`JTC_BSR_W-1:1]}; // [RULE15]
                dbg_q <= {tdi, dbg_q[`JTC_DBG_W-1:1]}; // [RULE18]
            end
            if (dr_upd && sel == SEL_BSR) begin
                bsr_upd_q <= bsr_q; // [RULE16]
            end
            // abort drops only the pending mark; a request already
            // queued toward the core still completes
            if (dr_upd && sel == SEL_ABT) begin
                abort_out <= dbg_q[3]; // [RULE19]
                err_clear_out <= dbg_q[7:4];
                pend_q <= 1'b0;
            end
            if (fifo_ok && !pend_q) begin
                pend_q <= 1'b1; // [RULE20]
            end else if (dr_upd && (sel == SEL_DP || sel == SEL_AP)) begin
                ack_q <= `JTC_ACK_WAIT;
            end
            if (fall) begin
                // only move on the falling edge for the next device
                tdo_oe_out <= (st_q == S_SHDR) || (st_q == S_SHIR);
                tdo_out <= (st_q == S_SHIR) ? ir_sh_q[0] : ser_out; // [RULE21]
            end
        end
    end

    // ======================================================
    // boundary cell multiplexers
    integer i;
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pad_out_out <= {`JTC_NPADS{1'b0}};
            pad_oe_out <= {`JTC_NPADS{1'b0}};
            core_in_out <= {`JTC_NPADS{1'b0}};
        end else begin
            for (i = 0; i < `JTC_NPADS; i = i + 1) begin
                if (ir_q == `JTC_IR_EXTEST) begin
                    pad_out_out[i] <= bsr_upd_q[3*i+1]; // [RULE2]
                    pad_oe_out[i] <= bsr_upd_q[3*i+2];
                end else begin
                    pad_out_out[i] <= core_out_in[i];
                    pad_oe_out[i] <= core_oe_in[i];
                end
                if (ir_q == `JTC_IR_INTEST && i != `JTC_RSTPAD) begin
                    core_in_out[i] <= bsr_upd_q[3*i]; // [RULE3] [RULE17]
                end else begin
                    core_in_out[i] <= pad_s2_q[i];
                end
            end
        end
    end

    // ======================================================
    // debug request path
    wire fv;
    wire [`JTC_DBG_W-1:0] fd;
    jtc_fifo #(
        .W(`JTC_FIFO_W),
        .D(`JTC_FIFO_D),
        .AW(`JTC_FIFO_AW),
        .CW(`JTC_FIFO_CW)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(fifo_ok && !pend_q),
        .in_ready_out(fifo_rdy),
        .in_data_in(sel == SEL_AP ? {dbg_q[34:3], 1'b1, dbg_q[1:0]}
            : {dbg_q[34:3], 1'b0, dbg_q[1:0]}),
        .out_valid_out(fv),
        .out_ready_in(!req_valid_out || req_ready_in),
        .out_data_out(fd)
    );
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            req_valid_out <= 1'b0;
            req_data_out <= {`JTC_DBG_W{1'b0}};
        end else if (!req_valid_out || req_ready_in) begin
            req_valid_out <= fv;
            req_data_out <= fd;
        end
    end
endmodule

// >>> verif/jtc_chains_chk.sv
// Purpose: port checks for the test access port chains
// Assumes: tck sampled by mclk, each half period at least 4 mclk
// Notes: attached to every instance of the chains block by bind
`include "jtc_defines.vh"
module jtc_chains_chk (
    input wire mclk_in,
    input wire rst_in,
    input wire tck_in,
    input wire trst_n_in,
    input wire tdo_out,
    input wire tdo_oe_out,
    input wire [`JTC_NPADS-1:0] pad_in_in,
    input wire [`JTC_NPADS-1:0] core_in_out,
    input wire req_valid_out,
    input wire req_ready_in,
    input wire [`JTC_DBG_W-1:0] req_data_out,
    input wire abort_out,
    input wire [3:0] err_clear_out
);
    timeunit 1ns;
    timeprecision 100ps;
    reg tck_q;
    reg [3:0] age_q;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // ========
    // cycles since the test clock fell; saturates so changes during long idles stay illegal
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tck_q <= 1'b0;
            age_q <= 4'hf;
        end else begin
            tck_q <= tck_in;
            if (tck_q && !tck_in)
                age_q <= 4'h0;
            else if (age_q != 4'hf)
                age_q <= age_q + 4'h1;
        end
    end
    sequence s_req_stall;
        req_valid_out && !req_ready_in;
    endsequence
    sequence s_trst_held;
        !trst_n_in [*4];
    endsequence
    AST_TDO_EDGE: assert property (
        $changed(tdo_out) |-> age_q inside {[1:7]})
        else $error("tdo moved away from a tck fall");
    AST_OE_EDGE: assert property (
        $changed(tdo_oe_out) |-> age_q inside {[1:7]})
        else $error("tdo enable moved away from a tck fall");
    AST_TDO_STANDS: assert property (
        $changed(tdo_out) |=> $stable(tdo_out) [*4])
        else $error("tdo did not hold");
    AST_RST_PAD: assert property (
        $stable(pad_in_in[0]) [*4] |-> core_in_out[0] == pad_in_in[0])
        else $error("reset pad input was driven from the chain");
    AST_REQ_HOLD: assert property (
        s_req_stall |=> req_valid_out && $stable(req_data_out))
        else $error("debug request dropped while stalled");
    AST_ABORT_PULSE: assert property (
        abort_out |=> !abort_out)
        else $error("abort longer than one cycle");
    AST_CLEAR_PULSE: assert property (
        err_clear_out != 4'h0 |=> err_clear_out == 4'h0)
        else $error("error clear longer than one cycle");
    AST_TRST_IDLE: assert property (
        s_trst_held |=> !$rose(tdo_oe_out))
        else $error("shift opened under test reset");
endmodule
bind jtc_chains jtc_chains_chk chk_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .tck_in(tck_in), .trst_n_in(trst_n_in), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .pad_in_in(pad_in_in),
    .core_in_out(core_in_out), .req_valid_out(req_valid_out),
    .req_ready_in(req_ready_in), .req_data_out(req_data_out),
    .abort_out(abort_out), .err_clear_out(err_clear_out));

// >>> verif/jtc_dbg_resp.sv
// Purpose: core-side responder for debug requests
// Assumes: one request outstanding, answer delay_in + 1 cycles after acceptance
// Notes: reply data is the request's upper 32 bits
`include "jtc_defines.vh"
module jtc_dbg_resp (
    input wire mclk_in,
    input wire rst_in,
    input wire [15:0] delay_in,
    input wire req_valid_in,
    output reg req_ready_out,
    input wire [34:0] req_data_in,
    output reg rsp_valid_out,
    output reg [31:0] rsp_data_out,
    output reg [2:0] rsp_ack_out,
    output reg [34:0] last_req_out
);
    timeunit 1ns;
    timeprecision 100ps;
    reg busy_q;
    reg [15:0] wait_q;
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 32'h0;
            rsp_ack_out <= 3'h0;
            last_req_out <= 35'h0;
            busy_q <= 1'b0;
            wait_q <= 16'h0;
        end else begin
            rsp_valid_out <= 1'b0;
            // idle reply data lines toggle so stale data is never trusted
            rsp_data_out <= ~rsp_data_out;
            req_ready_out <= !busy_q;
            if (req_valid_in && req_ready_out) begin
                req_ready_out <= 1'b0;
                busy_q <= 1'b1;
                wait_q <= delay_in;
                last_req_out <= req_data_in;
            end else if (busy_q && wait_q == 16'h0) begin
                busy_q <= 1'b0;
                rsp_valid_out <= 1'b1;
                rsp_data_out <= last_req_out[34:3];
                rsp_ack_out <= `JTC_ACK_OK;
            end else if (busy_q) begin
                wait_q <= wait_q - 16'h1;
            end
        end
    end
endmodule

// >>> verif/test_jtag_ir_and_data_chains.sv
// Purpose: self-checking bench for the test access port chains
// Assumes: tester drives tck at 64 ns, pins change on mclk falls
// Notes: expected chain contents come from the bench's own model
`include "jtc_defines.vh"
module test_jtag_ir_and_data_chains;
    timeunit 1ns;
    timeprecision 100ps;
    reg mclk, rst, tck, tms, tdi, trst_n, q, ab_seen;
    reg [7:0] pad_in, core_out, core_oe;
    reg [15:0] delay;
    reg [31:0] r;
    reg [3:0] clr_seen;
    reg [23:0] hold_m;
    reg [34:0] d, d1, d2, dout, exp_v;
    integer bad_count, check_count, cyc, c, k;
    wire tdo, tdo_oe, req_valid, req_ready, rsp_valid, abort_p;
    wire [7:0] pad_out, pad_oe, core_in;
    wire [34:0] req_data, last_req;
    wire [31:0] rsp_data;
    wire [2:0] rsp_ack;
    wire [3:0] err_clr;
    jtc_chains dut_u (.mclk_in(mclk), .rst_in(rst), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo),
        .tdo_oe_out(tdo_oe), .pad_in_in(pad_in), .core_out_in(core_out),
        .core_oe_in(core_oe), .pad_out_out(pad_out), .pad_oe_out(pad_oe),
        .core_in_out(core_in), .req_valid_out(req_valid),
        .req_ready_in(req_ready), .req_data_out(req_data),
        .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
        .rsp_ack_in(rsp_ack), .abort_out(abort_p), .err_clear_out(err_clr));
    jtc_dbg_resp resp_u (.mclk_in(mclk), .rst_in(rst), .delay_in(delay),
        .req_valid_in(req_valid), .req_ready_out(req_ready),
        .req_data_in(req_data), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .rsp_ack_out(rsp_ack),
        .last_req_out(last_req));
    // ========
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (abort_p) ab_seen <= 1'b1;
        if (err_clr != 4'h0) clr_seen <= err_clr;
        if (cyc == 60000) begin
            bad_count = bad_count + 1;
            give_verdict;
        end
    end
    task chk(input reg [34:0] got, input reg [34:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask
    // one tck period; tdo is read just before the rising edge
    task tap(input reg m, input reg b);
        begin
            tms = m;
            tdi = b;
            repeat (8) @(negedge mclk);
            q = tdo;
            tck = 1'b1;
            repeat (8) @(negedge mclk);
            tck = 1'b0;
        end
    endtask
    // from run-test-idle through capture, shift, update, back to idle
    task scan(input reg ir, input integer n, input reg [34:0] din);
        integer i;
        begin
            dout = 35'h0;
            tap(1'b1, 1'b1);
            if (ir) tap(1'b1, 1'b1);
            tap(1'b0, 1'b1);
            tap(1'b0, 1'b1);
            for (i = 0; i < n; i = i + 1) begin
                tap(i == n - 1, din[i]);
                dout[i] = q;
            end
            tap(1'b1, 1'b1);
            tap(1'b0, 1'b1);
            repeat (8) @(negedge mclk);
        end
    endtask
    function [7:0] fld(input [23:0] h, input integer o);
        integer j;
        begin
            for (j = 0; j < 8; j = j + 1) fld[j] = h[3 * j + o];
        end
    endfunction
    function [34:0] rnd35;
        reg [31:0] a, b;
        begin
            a = $urandom;
            b = $urandom;
            rnd35 = {a[2:0], b};
        end
    endfunction
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        {rst, tck, tms, tdi, trst_n} = 5'b10111;
        {pad_in, core_out, core_oe, delay} = 40'h0;
        {ab_seen, clr_seen, bad_count, check_count, cyc} = 0;
        void'($urandom(32'hf4a7));
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        tap(1'b0, 1'b1);
        scan(1'b0, 32, 35'h0);
        chk(dout, `JTC_IDCODE_VAL);
        chk(dout[0], 1'b1);
        scan(1'b1, 4, 35'hf);
        chk(dout[1:0], 2'b01);
        $display("test identity done");
        for (c = 0; c < 16; c = c + 1) begin
            if (!(c inside {0, 1, 2, 8, 10, 11, 14})) begin
                scan(1'b1, 4, c);
                d = rnd35();
                scan(1'b0, 8, d);
                chk(dout, {d[6:0], 1'b0});
            end
        end
        $display("test bypass done");
        r = $urandom;
        {pad_in, core_out, core_oe} = r[23:0];
        scan(1'b1, 4, `JTC_IR_SAMPLE);
        d = rnd35();
        scan(1'b0, 24, d);
        hold_m = d[23:0];
        for (k = 0; k < 8; k = k + 1)
            exp_v[3 * k +: 3] = {core_oe[k], core_out[k], pad_in[k]};
        chk(dout, exp_v[23:0]);
        $display("test sample done");
        scan(1'b1, 4, `JTC_IR_EXTEST);
        chk({pad_oe, pad_out}, {fld(hold_m, 2), fld(hold_m, 1)});
        for (k = 0; k < 8; k = k + 1)
            exp_v[3 * k +: 3] = {hold_m[3 * k + 1 +: 2], pad_in[k]};
        d = rnd35();
        d[0] = ~pad_in[0];
        scan(1'b0, 24, d);
        chk(dout, exp_v[23:0]);
        hold_m = d[23:0];
        chk({pad_oe, pad_out}, {fld(hold_m, 2), fld(hold_m, 1)});
        scan(1'b1, 4, `JTC_IR_INTEST);
        chk(core_in, {fld(hold_m, 0) >> 1, pad_in[0]} >> 0);
        $display("test boundary done");
        delay = 16'h4;
        d1 = rnd35() & ~35'h4;
        scan(1'b1, 4, 4'ha);
        scan(1'b0, 35, d1);
        chk(last_req, d1);
        d2 = rnd35() | 35'h4;
        scan(1'b1, 4, 4'hb);
        scan(1'b0, 35, d2);
        chk(dout, {d1[34:3], `JTC_ACK_OK});
        chk(last_req, d2);
        delay = 16'd3000;
        scan(1'b1, 4, 4'ha);
        d1 = rnd35() & ~35'h4;
        scan(1'b0, 35, d1);
        scan(1'b0, 35, rnd35() & ~35'h4);
        chk(dout[2:0], `JTC_ACK_WAIT);
        repeat (3100) @(negedge mclk);
        scan(1'b0, 35, 35'h0);
        chk(dout, {d1[34:3], `JTC_ACK_OK});
        delay = 16'h0;
        $display("test debug access done");
        scan(1'b1, 4, `JTC_IR_ABORT);
        d = rnd35() | 35'h8;
        ab_seen = 1'b0;
        scan(1'b0, 35, d);
        chk({ab_seen, clr_seen}, {1'b1, d[7:4]});
        scan(1'b1, 4, `JTC_IR_DP_ACCESS);
        d2 = rnd35() & ~35'h4;
        scan(1'b0, 35, d2);
        chk(dout, {d1[34:3], `JTC_ACK_OK});
        chk(req_data, d2);
        chk(req_valid, 1'b1);
        $display("test abort done");
        trst_n = 1'b0;
        repeat (6) @(negedge mclk);
        trst_n = 1'b1;
        repeat (4) @(negedge mclk);
        tap(1'b0, 1'b1);
        scan(1'b0, 32, 35'h0);
        chk(dout, `JTC_IDCODE_VAL);
        scan(1'b1, 4, `JTC_IR_BYPASS);
        for (k = 0; k < 5; k = k + 1) tap(1'b1, 1'b1);
        tap(1'b0, 1'b1);
        scan(1'b0, 32, 35'h0);
        chk(dout, `JTC_IDCODE_VAL);
        $display("test resets done");
        give_verdict;
    end
endmodule
